// ===== rtl/tps_pkg.sv
// shared constants and types for the periodic split response block
package tps_pkg;
   localparam int CLK_NS = 40;
   localparam int MFRAME_NS = 125000;
   // longest time rounds down
   localparam int MFRAME_CYC = MFRAME_NS / CLK_NS;
   // end-of-frame point, measured back from the end of microframe 7
   localparam int EOF_LEAD_NS = 4000;
   localparam int EOF_CYC = MFRAME_CYC - EOF_LEAD_NS / CLK_NS;
   localparam int HOLD_BYTES = 2;
   localparam logic [2:0] INT_ABORT_MF = 3'h4;
   localparam logic [2:0] LAST_MF = 3'h7;
   localparam int NUM_ENT = 16;
   localparam int MAX_LAUNCH = 16;
   localparam int LEN_W = 10;
   localparam int TAG_W = 4;
   localparam int STRM_W = 3 + TAG_W + 8;

   typedef enum logic [2:0]
   {
      RSP_NYET = 3'b000,
      RSP_DATA0 = 3'b001,
      RSP_DATA1 = 3'b010,
      RSP_MDATA = 3'b011,
      RSP_ERR = 3'b100,
      RSP_ACK = 3'b101,
      RSP_NAK = 3'b110,
      RSP_STALL = 3'b111
   } tps_resp_t;

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_ACTIVE = 2'b01,
      ST_ABORTED = 2'b10
   } tps_state_t;

   // microframe number arithmetic, wraps at eight
   function automatic logic [2:0] mfAdd(input logic [2:0] a,
                                        input logic [2:0] b);
      mfAdd = a + b;
   endfunction
endpackage

// ===== rtl/tps_ifs.sv
// stream and microframe timer carriers between block modules
interface tps_strm_if #(parameter int W = 8);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

interface tps_tmr_if;
   logic newMf;
   logic eof;
   logic [2:0] mfNum;
   modport prov (output newMf, output eof, output mfNum);
   modport use_ (input newMf, input eof, input mfNum);
endinterface

// ===== rtl/tps_mframe_timer.sv
// microframe and frame timer kept in step with high-speed sofs
module tps_mframe_timer
   import tps_pkg::*;
   #(parameter int PERIOD = MFRAME_CYC,
     parameter int EOF_AT = EOF_CYC)
   (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic hsSof,
   input wire logic hsFrameChg,
   tps_tmr_if.prov tmr
   );
   initial
   begin
      if (PERIOD < 8 || PERIOD > 4096 || EOF_AT >= PERIOD || EOF_AT < 1)
         $error("tps_mframe_timer: bad period");
   end

   logic [11:0] cnt_ff, nxt_cnt;
   logic [2:0] mf_ff, nxt_mf;
   logic newMf_ff, nxt_newMf;
   logic eof_ff, nxt_eof;

   always_comb
   begin
      nxt_cnt = cnt_ff + 12'h001;
      nxt_mf = mf_ff;
      nxt_newMf = 1'b0;
      nxt_eof = (mf_ff == LAST_MF) && (cnt_ff == 12'(EOF_AT));
      if (hsSof)
      begin
         // zeroth microframe when the frame number changes
         nxt_cnt = 12'h000;
         nxt_mf = hsFrameChg ? 3'h0 : mfAdd(mf_ff, 3'h1);
         nxt_newMf = 1'b1;
      end
      else if (cnt_ff == 12'(PERIOD - 1))
      begin
         // free-run across a missed sof
         nxt_cnt = 12'h000;
         nxt_mf = mfAdd(mf_ff, 3'h1);
         nxt_newMf = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         cnt_ff <= 12'h000;
         mf_ff <= 3'h0;
         newMf_ff <= 1'b0;
         eof_ff <= 1'b0;
      end
      else
      begin
         cnt_ff <= nxt_cnt;
         mf_ff <= nxt_mf;
         newMf_ff <= nxt_newMf;
         eof_ff <= nxt_eof;
      end
   end

   assign tmr.newMf = newMf_ff;
   assign tmr.mfNum = mf_ff;
   assign tmr.eof = eof_ff;
endmodule

// ===== rtl/tps_skid_buf.sv
// two-entry buffer with valid and ready on both sides
module tps_skid_buf
   #(parameter int W = 8)
   (
   input wire logic sys_clk,
   input wire logic rst,
   tps_strm_if.snk inS,
   tps_strm_if.src outS
   );
   initial
   begin
      if (W < 1)
         $error("tps_skid_buf: bad width");
   end

   logic [W-1:0] mem_ff [2];
   logic [W-1:0] nxt_mem [2];
   logic rdIdx_ff, nxt_rdIdx;
   logic [1:0] cnt_ff, nxt_cnt;
   logic wrEn, rdEn;

   assign inS.ready = (cnt_ff != 2'h2);
   assign outS.valid = (cnt_ff != 2'h0);
   assign outS.data = mem_ff[rdIdx_ff];
   assign wrEn = inS.valid && inS.ready;
   assign rdEn = outS.valid && outS.ready;

   always_comb
   begin
      nxt_mem = mem_ff;
      if (wrEn)
         nxt_mem[rdIdx_ff ^ cnt_ff[0]] = inS.data;
      nxt_rdIdx = rdEn ? ~rdIdx_ff : rdIdx_ff;
      nxt_cnt = cnt_ff + {1'b0, wrEn} - {1'b0, rdEn};
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         mem_ff[0] <= '0;
         mem_ff[1] <= '0;
         rdIdx_ff <= 1'b0;
         cnt_ff <= 2'h0;
      end
      else
      begin
         mem_ff <= nxt_mem;
         rdIdx_ff <= nxt_rdIdx;
         cnt_ff <= nxt_cnt;
      end
   end
endmodule

// ===== rtl/tps_periodic_split_response.sv
// periodic complete-split response and downstream abort logic
module tps_periodic_split_response
   import tps_pkg::*;
   #(parameter int ENTRIES = NUM_ENT,
     parameter int LAUNCH_MAX = MAX_LAUNCH,
     parameter int PERIOD = MFRAME_CYC,
     parameter int EOF_AT = EOF_CYC)
   (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic hsSof,
   input wire logic hsFrameChg,
   input wire logic csReq,
   input wire logic [TAG_W-1:0] csTag,
   output logic csAck,
   output tps_resp_t csCode,
   output logic [LEN_W-1:0] csLen,
   output logic launchOk,
   input wire logic dsStart,
   input wire logic [TAG_W-1:0] dsTag,
   input wire logic dsIsInt,
   input wire logic dsIsIn,
   input wire logic [2:0] dsSsMf,
   input wire logic dsTokenSent,
   input wire logic dsDataPhase,
   input wire logic dsHskStarted,
   input wire logic dsByteValid,
   input wire logic [7:0] dsByte,
   output logic dsByteReady,
   input wire logic dsEnd,
   input wire logic dsCrcOk,
   input wire logic dsDataPid,
   input wire logic [2:0] dsOutHsk,
   output logic abortReq,
   output logic skipToken,
   output logic withholdHsk,
   output logic stopOutBytes,
   output logic forceStuffErr,
   output logic rdValid,
   input wire logic rdReady,
   output logic [STRM_W-1:0] rdData
   );
   initial
   begin
      if (ENTRIES != (1 << TAG_W) || LAUNCH_MAX < 1 || LAUNCH_MAX > 31)
         $error("tps_periodic_split_response: bad parameters");
   end

   tps_tmr_if tmr ();
   tps_strm_if #(.W(STRM_W)) relS ();
   tps_strm_if #(.W(STRM_W)) outS ();

   tps_mframe_timer #(.PERIOD(PERIOD), .EOF_AT(EOF_AT)) uTimer
   (
      .sys_clk(sys_clk),
      .rst(rst),
      .hsSof(hsSof),
      .hsFrameChg(hsFrameChg),
      .tmr(tmr.prov)
   );

   tps_skid_buf #(.W(STRM_W)) uBuf
   (
      .sys_clk(sys_clk),
      .rst(rst),
      .inS(relS.snk),
      .outS(outS.src)
   );

   assign rdValid = outS.valid;
   assign rdData = outS.data;
   assign outS.ready = rdReady;

   tps_state_t state_ff, nxt_state;
   logic [TAG_W-1:0] curTag_ff, nxt_curTag;
   logic curInt_ff, nxt_curInt, curIn_ff, nxt_curIn;
   logic [2:0] curSsMf_ff, nxt_curSsMf;
   logic [7:0] hold0_ff, nxt_hold0, hold1_ff, nxt_hold1;
   logic [1:0] holdCnt_ff, nxt_holdCnt;
   logic [LEN_W-1:0] rxTot_ff, nxt_rxTot, mfLen_ff, nxt_mfLen;
   logic [4:0] launchCnt_ff, nxt_launchCnt;
   logic abTok_ff, nxt_abTok, abData_ff, nxt_abData;
   logic abHsk_ff, nxt_abHsk, abPulse_ff, nxt_abPulse;
   logic entValid_ff [ENTRIES], nxt_entValid [ENTRIES];
   tps_resp_t entCode_ff [ENTRIES], nxt_entCode [ENTRIES];
   logic [2:0] entMf_ff [ENTRIES], nxt_entMf [ENTRIES];
   logic [LEN_W-1:0] entLen_ff [ENTRIES], nxt_entLen [ENTRIES];
   logic csAck_ff, nxt_csAck;
   tps_resp_t csCode_ff, nxt_csCode;
   logic [LEN_W-1:0] csLen_ff, nxt_csLen;
   logic active, byteAcc, push, abortNow, hasFree;

   assign active = (state_ff == ST_ACTIVE);
   // aborted packets are drained and dropped
   assign dsByteReady = !active || holdCnt_ff != 2'h2 || relS.ready;
   assign byteAcc = dsByteValid && dsByteReady;
   // the two newest bytes are held back as possible crc
   assign push = active && byteAcc && holdCnt_ff == 2'h2;
   assign relS.valid = active && dsByteValid && holdCnt_ff == 2'h2;
   assign relS.data = {tmr.mfNum, curTag_ff, hold1_ff};
   assign abortNow = active && (tmr.eof
      || (curInt_ff && tmr.newMf
      && tmr.mfNum == mfAdd(curSsMf_ff, INT_ABORT_MF)));

   always_comb
   begin
      hasFree = 1'b0;
      for (int i = 0; i < ENTRIES; i++)
         hasFree = hasFree | !entValid_ff[i];
   end

   assign launchOk = (state_ff == ST_IDLE) && hasFree
      && launchCnt_ff < 5'(LAUNCH_MAX);

   always_comb
   begin
      nxt_state = state_ff;
      nxt_curTag = curTag_ff;
      nxt_curInt = curInt_ff;
      nxt_curIn = curIn_ff;
      nxt_curSsMf = curSsMf_ff;
      nxt_hold0 = hold0_ff;
      nxt_hold1 = hold1_ff;
      nxt_holdCnt = holdCnt_ff;
      nxt_rxTot = rxTot_ff;
      nxt_mfLen = tmr.newMf ? '0 : mfLen_ff;
      nxt_launchCnt = tmr.newMf ? 5'h00 : launchCnt_ff;
      nxt_abTok = abTok_ff;
      nxt_abData = abData_ff;
      nxt_abHsk = abHsk_ff;
      nxt_abPulse = 1'b0;
      nxt_entValid = entValid_ff;
      nxt_entCode = entCode_ff;
      nxt_entMf = entMf_ff;
      nxt_entLen = entLen_ff;
      if (tmr.newMf)
      begin
         for (int i = 0; i < ENTRIES; i++)
            if (entMf_ff[i] == mfAdd(tmr.mfNum, 3'h6))
               nxt_entValid[i] = 1'b0;
      end
      if (active && byteAcc)
      begin
         nxt_hold1 = hold0_ff;
         nxt_hold0 = dsByte;
         // saturates so a long packet with crc cannot wrap to few bytes
         if (rxTot_ff != '1)
            nxt_rxTot = rxTot_ff + 10'h001;
         if (holdCnt_ff != 2'h2)
            nxt_holdCnt = holdCnt_ff + 2'h1;
      end
      if (push)
         nxt_mfLen = nxt_mfLen + 10'h001;
      unique case (state_ff)
         ST_IDLE:
         begin
            if (dsStart && launchOk)
            begin
               nxt_state = ST_ACTIVE;
               nxt_curTag = dsTag;
               nxt_curInt = dsIsInt;
               nxt_curIn = dsIsIn;
               nxt_curSsMf = dsSsMf;
               nxt_holdCnt = 2'h0;
               nxt_rxTot = '0;
               nxt_mfLen = '0;
               nxt_launchCnt = nxt_launchCnt + 5'h01;
            end
         end
         ST_ACTIVE:
         begin
            if (abortNow)
            begin
               // no entry is written for this transaction
               nxt_state = dsEnd ? ST_IDLE : ST_ABORTED;
               nxt_abPulse = 1'b1;
               nxt_abTok = !dsTokenSent;
               nxt_abHsk = !dsHskStarted;
               nxt_abData = dsDataPhase;
            end
            else if (dsEnd)
            begin
               nxt_state = ST_IDLE;
               nxt_entValid[curTag_ff] = 1'b1;
               nxt_entMf[curTag_ff] = tmr.mfNum;
               nxt_entLen[curTag_ff] = mfLen_ff + {9'h000, push};
               if (!curIn_ff)
                  nxt_entCode[curTag_ff] = tps_resp_t'(dsOutHsk);
               else if (!dsCrcOk)
                  nxt_entCode[curTag_ff] = RSP_ERR;
               else if (curInt_ff && dsDataPid)
                  nxt_entCode[curTag_ff] = RSP_DATA1;
               else
                  nxt_entCode[curTag_ff] = RSP_DATA0;
            end
            else if (tmr.newMf && curIn_ff && rxTot_ff > 10'h002)
            begin
               // data of the closing microframe, minus held bytes
               // the tag's one entry is rewritten at each boundary crossed
               nxt_entValid[curTag_ff] = 1'b1;
               nxt_entCode[curTag_ff] = RSP_MDATA;
               nxt_entMf[curTag_ff] = mfAdd(tmr.mfNum, 3'h7);
               nxt_entLen[curTag_ff] = mfLen_ff;
            end
            // fewer bytes leave no entry, so the split sees NYET
         end
         ST_ABORTED:
         begin
            if (dsEnd)
               nxt_state = ST_IDLE;
         end
         default:
            nxt_state = ST_IDLE;
      endcase
   end

   // complete-split lookup, answered one cycle later
   always_comb
   begin
      nxt_csAck = csReq;
      nxt_csCode = csCode_ff;
      nxt_csLen = csLen_ff;
      if (csReq)
      begin
         nxt_csCode = entValid_ff[csTag] ? entCode_ff[csTag] : RSP_NYET;
         nxt_csLen = entValid_ff[csTag] ? entLen_ff[csTag] : '0;
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         state_ff <= ST_IDLE;
         curTag_ff <= '0;
         curInt_ff <= 1'b0;
         curIn_ff <= 1'b0;
         curSsMf_ff <= 3'h0;
         hold0_ff <= 8'h00;
         hold1_ff <= 8'h00;
         holdCnt_ff <= 2'h0;
         rxTot_ff <= '0;
         mfLen_ff <= '0;
         launchCnt_ff <= 5'h00;
         abTok_ff <= 1'b0;
         abData_ff <= 1'b0;
         abHsk_ff <= 1'b0;
         abPulse_ff <= 1'b0;
         for (int i = 0; i < ENTRIES; i++)
         begin
            entValid_ff[i] <= 1'b0;
            entCode_ff[i] <= RSP_NYET;
            entMf_ff[i] <= 3'h0;
            entLen_ff[i] <= '0;
         end
         csAck_ff <= 1'b0;
         csCode_ff <= RSP_NYET;
         csLen_ff <= '0;
      end
      else
      begin
         state_ff <= nxt_state;
         curTag_ff <= nxt_curTag;
         curInt_ff <= nxt_curInt;
         curIn_ff <= nxt_curIn;
         curSsMf_ff <= nxt_curSsMf;
         hold0_ff <= nxt_hold0;
         hold1_ff <= nxt_hold1;
         holdCnt_ff <= nxt_holdCnt;
         rxTot_ff <= nxt_rxTot;
         mfLen_ff <= nxt_mfLen;
         launchCnt_ff <= nxt_launchCnt;
         abTok_ff <= nxt_abTok;
         abData_ff <= nxt_abData;
         abHsk_ff <= nxt_abHsk;
         abPulse_ff <= nxt_abPulse;
         entValid_ff <= nxt_entValid;
         entCode_ff <= nxt_entCode;
         entMf_ff <= nxt_entMf;
         entLen_ff <= nxt_entLen;
         csAck_ff <= nxt_csAck;
         csCode_ff <= nxt_csCode;
         csLen_ff <= nxt_csLen;
      end
   end

   assign csAck = csAck_ff;
   assign csCode = csCode_ff;
   assign csLen = csLen_ff;
   assign abortReq = abPulse_ff;
   // downstream abort actions while the aborted packet drains
   assign skipToken = (state_ff == ST_ABORTED) && abTok_ff;
   assign withholdHsk = (state_ff == ST_ABORTED) && curIn_ff
      && abHsk_ff;
   assign stopOutBytes = (state_ff == ST_ABORTED) && !curIn_ff;
   assign forceStuffErr = stopOutBytes && abData_ff;

   a_nyet_no_entry: assert property (@(posedge sys_clk) disable iff (rst)
      csReq && !entValid_ff[csTag] |=> csAck && csCode == RSP_NYET)
      else $error("missing entry not answered nyet");

   a_iso_data_zero: assert property (@(posedge sys_clk) disable iff (rst)
      active && dsEnd && !abortNow && curIn_ff && !curInt_ff && dsCrcOk
      |=> entCode_ff[$past(curTag_ff)] == RSP_DATA0)
      else $error("isochronous result not data0");

   a_bad_crc_err: assert property (@(posedge sys_clk) disable iff (rst)
      active && dsEnd && !abortNow && curIn_ff && !dsCrcOk
      |=> entCode_ff[$past(curTag_ff)] == RSP_ERR)
      else $error("bad crc not answered err");

   a_mdata_boundary: assert property (@(posedge sys_clk) disable iff (rst)
      active && tmr.newMf && !abortNow && !dsEnd && curIn_ff
      && rxTot_ff > 10'h002
      |=> entValid_ff[$past(curTag_ff)]
      && entLen_ff[$past(curTag_ff)] == $past(mfLen_ff))
      else $error("mdata entry wrong");

   a_crc_held_back: assert property (@(posedge sys_clk) disable iff (rst)
      active && byteAcc ##1 active && byteAcc |-> !relS.valid
      || $past(holdCnt_ff) != 2'h0)
      else $error("crc byte released too early");

   a_eof_abort: assert property (@(posedge sys_clk) disable iff (rst)
      active && tmr.eof && !dsEnd |=> state_ff == ST_ABORTED ##0 abortReq)
      else $error("eof did not abort");

   a_int_deadline: assert property (@(posedge sys_clk) disable iff (rst)
      active && curInt_ff && tmr.newMf && !dsEnd
      && tmr.mfNum == mfAdd(curSsMf_ff, INT_ABORT_MF)
      |=> state_ff == ST_ABORTED)
      else $error("interrupt deadline missed");

   a_abort_no_entry: assert property (@(posedge sys_clk) disable iff (rst)
      state_ff == ST_ABORTED && dsEnd && !tmr.newMf
      |=> entValid_ff[curTag_ff] == $past(entValid_ff[curTag_ff]))
      else $error("aborted transaction made an entry");

   a_launch_limit: assert property (@(posedge sys_clk) disable iff (rst)
      state_ff == ST_IDLE && !tmr.newMf && launchCnt_ff == 5'(LAUNCH_MAX)
      |=> state_ff == ST_IDLE)
      else $error("too many launches");

   a_free_old: assert property (@(posedge sys_clk) disable iff (rst)
      tmr.newMf && !active && entMf_ff[0] == mfAdd(tmr.mfNum, 3'h6)
      |=> !entValid_ff[0])
      else $error("old entry not freed");
endmodule

// ===== sim/tps_host_model.sv
// host-side model issuing complete-splits and taking their answers
module tps_host_model
   import tps_pkg::*;
   (
   input wire logic sys_clk,
   output logic csReq,
   output logic [TAG_W-1:0] csTag,
   input wire logic csAck,
   input wire tps_resp_t csCode,
   input wire logic [LEN_W-1:0] csLen
   );
   timeunit 1ns;
   timeprecision 1ps;
   // tags whose transaction already gave its final answer
   logic [15:0] doneTag = '0;
   initial
   begin
      csReq = 1'b0;
      csTag = '0;
   end
   // new transaction on a tag, schedule starts over
   task automatic arm(input logic [TAG_W-1:0] t);
      doneTag[t] = 1'b0;
   endtask
   task automatic split(input logic [TAG_W-1:0] t, output tps_resp_t code,
                        output logic [LEN_W-1:0] len, output logic ok);
      int k;
      ok = 1'b0;
      code = RSP_NYET;
      len = '0;
      if (doneTag[t])
         return;
      csReq <= 1'b1;
      csTag <= t;
      @(posedge sys_clk);
      csReq <= 1'b0;
      csTag <= ~t;
      k = 0;
      do @(negedge sys_clk); while (csAck !== 1'b1 && ++k < 4);
      if (csAck === 1'b1)
      begin
         ok = 1'b1;
         code = csCode;
         len = csLen;
         // final data or handshake ends the schedule
         if (!(code inside {RSP_NYET, RSP_MDATA}))
            doneTag[t] = 1'b1;
      end
      @(posedge sys_clk);
   endtask
endmodule

// ===== sim/tps_periodic_split_response_tb_top.sv
// self-checking bench for the periodic split response block
module tps_periodic_split_response_tb_top import tps_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic isInt; logic isIn; logic pid; logic [3:0] n; logic crc;
      logic [2:0] hsk; tps_resp_t code; logic [LEN_W-1:0] len;
   } tps_row_t;
   localparam tps_row_t ROWS [8] = '{
      '{0, 1, 1, 5, 1, 0, RSP_DATA0, 3}, '{1, 1, 1, 4, 1, 0, RSP_DATA1, 2},
      '{1, 1, 0, 6, 1, 0, RSP_DATA0, 4}, '{0, 1, 0, 5, 0, 0, RSP_ERR, 0},
      '{1, 0, 0, 0, 1, 5, RSP_ACK, 0}, '{1, 0, 0, 0, 1, 6, RSP_NAK, 0},
      '{1, 0, 0, 0, 1, 7, RSP_STALL, 0}, '{0, 1, 0, 2, 1, 0, RSP_DATA0, 0}};
   logic sys_clk = 0, rst = 1, hsSof = 0, hsFrameChg = 0, rdReady = 1;
   logic dsStart = 0, dsIsInt = 0, dsIsIn = 0, dsTokenSent = 0;
   logic dsDataPhase = 0, dsHskStarted = 0, dsByteValid = 0, dsEnd = 0;
   logic dsCrcOk = 0, dsDataPid = 0;
   logic [TAG_W-1:0] dsTag = '0, csTag;
   logic [2:0] dsSsMf = '0, dsOutHsk = '0, mf = 3'h7;
   logic [7:0] dsByte = '0;
   logic csReq, csAck, launchOk, dsByteReady, abortReq, skipToken;
   logic withholdHsk, stopOutBytes, forceStuffErr, rdValid, ok;
   tps_resp_t csCode, code;
   logic [LEN_W-1:0] csLen, len;
   logic [STRM_W-1:0] rdData;
   logic [14:0] rq[$];
   int failures = 0, checked = 0, sofCnt = 0, k;
   tps_row_t r;
   always #20 sys_clk = ~sys_clk;
   // sof every 64 cycles, frame change on wrap to microframe 0
   always @(posedge sys_clk)
   begin
      sofCnt <= rst ? 0 : (sofCnt + 1) % 64;
      hsSof <= !rst && sofCnt == 62;
      if (!rst && sofCnt == 62)
      begin
         hsFrameChg <= mf == 3'h7;
         mf <= mf + 3'h1;
      end
   end
   always @(posedge sys_clk)
      if (rdValid && rdReady)
         rq.push_back(rdData);
   tps_periodic_split_response #(.PERIOD(64), .EOF_AT(40)) uut (
      .sys_clk, .rst, .hsSof, .hsFrameChg, .csReq, .csTag, .csAck,
      .csCode, .csLen, .launchOk, .dsStart, .dsTag, .dsIsInt, .dsIsIn,
      .dsSsMf, .dsTokenSent, .dsDataPhase, .dsHskStarted, .dsByteValid,
      .dsByte, .dsByteReady, .dsEnd, .dsCrcOk, .dsDataPid, .dsOutHsk,
      .abortReq, .skipToken, .withholdHsk, .stopOutBytes, .forceStuffErr,
      .rdValid, .rdReady, .rdData);
   tps_host_model host (.sys_clk, .csReq, .csTag, .csAck, .csCode, .csLen);
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic results;
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic waitHi(ref logic s, input int lim, output int n);
      n = 0;
      do begin @(posedge sys_clk); n++; end while (s !== 1'b1 && n < lim);
      if (s !== 1'b1)
      begin
         failures++;
         $display("unexpected at %0t: wait ran out", $time);
         results();
      end
   endtask
   task automatic waitSof;
      int n;
      waitHi(hsSof, 80, n);
      repeat (2) @(posedge sys_clk);
   endtask
   task automatic launch(input logic i, input logic o, input logic [3:0] t,
                         input logic [2:0] ss);
      chk(launchOk, 1);
      dsStart <= 1;
      dsIsInt <= i;
      dsIsIn <= o;
      dsTag <= t;
      dsSsMf <= ss;
      @(posedge sys_clk);
      dsStart <= 0;
      @(negedge sys_clk);
      chk(launchOk, 0);
      @(posedge sys_clk);
   endtask
   task automatic bytes(input int n, input logic [7:0] b);
      int w;
      for (int i = 0; i < n; i++)
      begin
         dsByteValid <= 1;
         dsByte <= b + 8'(i);
         waitHi(dsByteReady, 50, w);
      end
      dsByteValid <= 0;
   endtask
   task automatic endXfer(input logic c, input logic p, input logic [2:0] h);
      dsEnd <= 1;
      dsCrcOk <= c;
      dsDataPid <= p;
      dsOutHsk <= h;
      @(posedge sys_clk);
      dsEnd <= 0;
      @(posedge sys_clk);
   endtask
   task automatic ask(input logic [3:0] t, input tps_resp_t c,
                      input logic [LEN_W-1:0] l);
      host.arm(t);
      host.split(t, code, len, ok);
      chk(ok, 1);
      chk(code, c);
      if (c inside {RSP_DATA0, RSP_DATA1, RSP_MDATA})
         chk(len, l);
   endtask
   initial
   begin
      repeat (5) @(posedge sys_clk);
      @(negedge sys_clk);
      chk({csAck, abortReq, rdValid, launchOk, dsByteReady, csCode}, 8'h18);
      @(posedge sys_clk);
      rst <= 0;
      foreach (ROWS[i])
      begin
         r = ROWS[i];
         waitSof();
         rq.delete();
         launch(r.isInt, r.isIn, 4'(i + 1), mf);
         if (r.isIn)
            bytes(r.n, 8'h10);
         endXfer(r.crc, r.pid, r.hsk);
         ask(4'(i + 1), r.code, r.len);
         repeat (4) @(posedge sys_clk);
         chk(16'(rq.size()), r.isIn ? 16'(r.n - 2) : 16'h0);
         foreach (rq[j])
            chk(rq[j][11:0], {4'(i + 1), 8'h10 + 8'(j)});
      end
      waitSof();
      ask(4'h8, RSP_DATA0, 0);
      waitSof();
      ask(4'h8, RSP_NYET, 0);
      ask(4'hf, RSP_NYET, 0);
      waitSof();
      launch(0, 1, 4'h9, mf);
      bytes(5, 8'h40);
      waitSof();
      ask(4'h9, RSP_MDATA, 3);
      bytes(3, 8'h45);
      endXfer(1, 0, 0);
      ask(4'h9, RSP_DATA0, 3);
      waitSof();
      launch(1, 1, 4'ha, mf);
      bytes(2, 8'h50);
      waitSof();
      ask(4'ha, RSP_NYET, 0);
      endXfer(1, 1, 0);
      ask(4'ha, RSP_DATA1, 0);
      waitSof();
      dsTokenSent <= 1;
      dsDataPhase <= 1;
      launch(1, 1, 4'hb, mf - 3'h3);
      bytes(3, 8'h60);
      waitHi(abortReq, 80, k);
      chk({skipToken, withholdHsk, stopOutBytes, forceStuffErr},
         4'h4);
      rq.delete();
      bytes(3, 8'h63);
      endXfer(1, 0, 0);
      repeat (3) @(posedge sys_clk);
      chk(16'(rq.size()), 0);
      ask(4'hb, RSP_NYET, 0);
      // start of a fresh microframe 7, well before its eof point
      do
         waitSof();
      while (mf != 3'h7);
      dsTokenSent <= 0;
      launch(0, 0, 4'hc, 3'h6);
      waitHi(abortReq, 80, k);
      chk(16'(k > 30 && k < 45), 1);
      chk({skipToken, withholdHsk, stopOutBytes, forceStuffErr},
         4'hb);
      endXfer(1, 0, 5);
      ask(4'hc, RSP_NYET, 0);
      waitSof();
      rq.delete();
      rdReady <= 0;
      launch(0, 1, 4'hd, mf);
      dsByteValid <= 1;
      dsByte <= 8'h70;
      k = 0;
      repeat (10)
      begin
         @(posedge sys_clk);
         k += dsByteReady;
      end
      dsByteValid <= 0;
      chk(16'(k), 4);
      rdReady <= 1;
      repeat (4) @(posedge sys_clk);
      chk(16'(rq.size()), 2);
      endXfer(1, 0, 0);
      ask(4'hd, RSP_DATA0, 2);
      results();
   end
endmodule
